// File: rtl/pcs_defs.vh
// Purpose: constants for the clock synthesizer control block
// Assumes: included by bare name from pcs_lock_detect and pcs_clock_synth
// Notes: byte offsets on a 32-bit Avalon-MM slave
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

`define PCS_ADDR_W 4
`define PCS_FREQ_OFFSET 4'h0
`define PCS_MODE_OFFSET 4'h4
`define PCS_REG_RESET 16'h0000

// synth_frequency_control fields
`define PCS_YD_MSB 7
`define PCS_YD_LSB 0
`define PCS_ID_MSB 11
`define PCS_ID_LSB 8
`define PCS_PD_MSB 15
`define PCS_PD_LSB 12

// synth_mode_control fields
`define PCS_CS_MSB 11
`define PCS_CS_LSB 10
`define PCS_PS_BIT 12
`define PCS_PWROFF_BIT 13
`define PCS_SEL_BIT 14
`define PCS_LOCK_BIT 15
`define PCS_MODE_RW_MASK 16'h7C00

// clock_out_select codes
`define PCS_CS_PHASE0 2'h0
`define PCS_CS_RESERVED 2'h1
`define PCS_CS_EXT 2'h2
`define PCS_CS_EXT_HALF 2'h3

`define PCS_LOCK_REF_CYCLES 16
`define PCS_REF_W 20

`endif

// File: rtl/pcs_tick_divider.v
// Purpose: divides a stream of one-cycle ticks by a programmable ratio
// Assumes: tickIn is a one-cycle enable on clk_sys
// Notes: ratio is terminal+1; clear restarts the count
`timescale 1ns/1ps
`default_nettype none
module pcs_tick_divider #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire clear,
  input wire tickIn,
  input wire [WIDTH-1:0] terminal,
  output reg tickOut
);
  reg [WIDTH-1:0] count;

  always @(posedge clk_sys) begin
    if (srst || clear) begin
      count <= {WIDTH{1'b0}};
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tickIn) begin
        // compare with >= so a lowered ratio never runs the counter past wrap
        if (count >= terminal) begin
          count <= {WIDTH{1'b0}};
          tickOut <= 1'b1;
        end else begin
          count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // pcs_tick_divider
`default_nettype wire

// File: rtl/pcs_lock_detect.v
// Purpose: declares lock after feedback and reference phases agree for a run
// Assumes: refTick and fbTick are one-cycle enables on clk_sys
// Notes: restart drops lock at once and restarts the run
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.vh"
module pcs_lock_detect #(
  parameter LOCK_CYCLES = `PCS_LOCK_REF_CYCLES,
  parameter CW = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire restart,
  input wire refTick,
  input wire fbTick,
  output reg locked
);
  reg [CW-1:0] goodRun;
  reg [1:0] fbSeen;
  wire [1:0] fbTotal = fbSeen + {1'b0, fbTick};
  wire matched = (fbTotal == 2'h1);

  always @(posedge clk_sys) begin
    if (srst || restart) begin
      goodRun <= {CW{1'b0}};
      fbSeen <= 2'h0;
      locked <= 1'b0;
    end else if (refTick) begin
      fbSeen <= 2'h0;
      // exactly one feedback edge per reference period counts as in phase
      if (!matched) begin
        goodRun <= {CW{1'b0}};
        locked <= 1'b0;
      end else if (goodRun >= LOCK_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
        locked <= 1'b1;
      end else begin
        goodRun <= goodRun + {{(CW-1){1'b0}}, 1'b1};
      end
    end else if (fbTick && fbSeen != 2'h2) begin
      fbSeen <= fbSeen + 2'h1;
    end
  end
endmodule // pcs_lock_detect
`default_nettype wire

// File: rtl/pcs_clock_synth.v
// Purpose: clock synthesizer control with two software registers
// Assumes: external clock is far slower than clk_sys; Avalon-MM slave
// Notes: derived clocks are one-cycle enables; levels toggle on them
// Function
// [R01] synthesizer rate is ext/(ID+1)*(YD+1)/2^PD
// [R02] feedback divides by YD+1; write clears lock
// [R03] input divider divides ext by ID+1
// [R04] new input divider value clears lock
// [R05] post divider divides oscillator by 2^PD
// [R06] post divider writes leave lock alone
// [R07] registers read/write, zero on hardware reset
// [R08] output select drives clock output pin
// [R09] reset drives phase-zero clock on pin
// [R10] bypass source picks ext or divided ext
// [R11] power-off stops whole PLL, counters included
// [R12] setting power-off clears lock at once
// [R13] select with power on uses synthesizer
// [R14] lock flag is read-only status bit
// [R15] clearing select alone keeps lock
// [R16] stop keeps PLL; powered-off stop halts divider
// [R17] software bypasses before powering off
// [R18] software bypasses while reprogramming feedback
// [R19] software bypasses, powers off, then stops
// [R20] software writes zeros to reserved bits
// [R21] lock after matched run; cleared on changes
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.vh"
module pcs_clock_synth #(
  parameter LOCK_CYCLES = `PCS_LOCK_REF_CYCLES,
  parameter REF_W = `PCS_REF_W
) (
  input wire clk_sys,
  input wire srst,
  input wire [`PCS_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire externalClockInput,
  input wire stopMode,
  input wire clockOutDisable,
  output reg coreClockTick,
  output reg coreMasterClock,
  output reg corePhaseZeroClock,
  output reg clockOutputPin,
  output wire synthLocked
);
  function hitOffset;
    input [`PCS_ADDR_W-1:0] addr;
    input [`PCS_ADDR_W-1:0] offset;
    begin
      hitOffset = (addr == offset);
    end
  endfunction

  reg [15:0] freqCtrl;
  reg [15:0] modeCtrl;
  reg ack;

  wire [7:0] feedbackDivider = freqCtrl[`PCS_YD_MSB:`PCS_YD_LSB];
  wire [3:0] inputDivider = freqCtrl[`PCS_ID_MSB:`PCS_ID_LSB];
  wire [3:0] postDividerExponent = freqCtrl[`PCS_PD_MSB:`PCS_PD_LSB];
  wire [1:0] clockOutSelect = modeCtrl[`PCS_CS_MSB:`PCS_CS_LSB];
  wire bypassSourceSelect = modeCtrl[`PCS_PS_BIT];
  wire synthPowerOff = modeCtrl[`PCS_PWROFF_BIT];
  wire synthOutputSelect = modeCtrl[`PCS_SEL_BIT];

  // ---------------- register bus: one wait state per access
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  wire wrDone = avs_write & ack;
  wire wrFreq = wrDone & hitOffset(avs_address, `PCS_FREQ_OFFSET);
  wire wrMode = wrDone & hitOffset(avs_address, `PCS_MODE_OFFSET);

  wire ydWrite = wrFreq & avs_byteenable[0]; // R02
  wire idChange = wrFreq & avs_byteenable[1] &
                  (avs_writedata[`PCS_ID_MSB:`PCS_ID_LSB] != inputDivider); // R04
  // PD lives in the same byte as ID but only an ID change restarts lock
  wire powerOffSet = wrMode & avs_byteenable[1] & avs_writedata[`PCS_PWROFF_BIT]; // R12
  wire lockRestart = ydWrite | idChange | powerOffSet | synthPowerOff; // R06 R15 R21

  always @(posedge clk_sys) begin
    if (srst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (req && !ack) begin
        if (hitOffset(avs_address, `PCS_FREQ_OFFSET)) begin
          avs_readdata <= {16'h0000, freqCtrl};
        end else if (hitOffset(avs_address, `PCS_MODE_OFFSET)) begin
          avs_readdata <= {16'h0000, synthLocked, modeCtrl[14:0]}; // R14
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // only the hardware reset clears these; there is no software reset input
  always @(posedge clk_sys) begin
    if (srst) begin
      freqCtrl <= `PCS_REG_RESET; // R07
      modeCtrl <= `PCS_REG_RESET; // R07
    end else begin
      if (wrFreq && avs_byteenable[0]) begin
        freqCtrl[7:0] <= avs_writedata[7:0];
      end
      if (wrFreq && avs_byteenable[1]) begin
        freqCtrl[15:8] <= avs_writedata[15:8];
      end
      if (wrMode && avs_byteenable[1]) begin
        // reserved low bits and the lock bit are never stored
        modeCtrl <= avs_writedata[15:0] & `PCS_MODE_RW_MASK; // R14 R20
      end
    end
  end

  // ---------------- external clock conditioning
  reg [2:0] extSync;
  reg extLevel;
  reg extHalf;
  wire extRise = ~extLevel & extSync[1] & (extSync[1] == extSync[2]);

  always @(posedge clk_sys) begin
    if (srst) begin
      extSync <= 3'h0;
      extLevel <= 1'b0;
      extHalf <= 1'b0;
    end else begin
      extSync <= {extSync[1:0], externalClockInput};
      // accept a change only once the two later stages agree
      if (extSync[1] == extSync[2]) begin
        extLevel <= extSync[1];
      end
      if (extRise) begin
        extHalf <= ~extHalf;
      end
    end
  end

  // ---------------- input divider, halted only by a powered-off stop
  wire idHalted = stopMode & synthPowerOff; // R16
  wire idTick;

  pcs_tick_divider #(.WIDTH(4)) u_input_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .clear(idHalted),
    .tickIn(extRise),
    .terminal(inputDivider), // R03
    .tickOut(idTick)
  );

  // ---------------- oscillator model: YD+1 ticks per reference period
  reg [REF_W-1:0] refCount;
  reg [REF_W-1:0] refPeriod;
  reg [REF_W-1:0] phaseAcc;
  reg vcoTick;
  wire [REF_W-1:0] ydPlusOne = {{(REF_W-9){1'b0}}, 1'b0, feedbackDivider} + {{(REF_W-1){1'b0}}, 1'b1};
  wire [REF_W:0] phaseSum = {1'b0, phaseAcc} + {1'b0, ydPlusOne};

  // one tick per clk_sys at most: the oscillator must stay below clk_sys
  always @(posedge clk_sys) begin
    if (srst || synthPowerOff) begin
      refCount <= {REF_W{1'b0}}; // R11
      refPeriod <= {REF_W{1'b0}};
      phaseAcc <= {REF_W{1'b0}};
      vcoTick <= 1'b0;
    end else begin
      if (idTick) begin
        refPeriod <= refCount + {{(REF_W-1){1'b0}}, 1'b1};
        refCount <= {REF_W{1'b0}};
      end else if (refCount != {REF_W{1'b1}}) begin
        refCount <= refCount + {{(REF_W-1){1'b0}}, 1'b1};
      end
      vcoTick <= 1'b0;
      if (refPeriod != {REF_W{1'b0}}) begin
        if (phaseSum >= {1'b0, refPeriod}) begin
          phaseAcc <= phaseSum[REF_W-1:0] - refPeriod; // R01
          vcoTick <= 1'b1;
        end else begin
          phaseAcc <= phaseSum[REF_W-1:0];
        end
      end
    end
  end

  wire fbTick;

  pcs_tick_divider #(.WIDTH(8)) u_feedback_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .clear(synthPowerOff), // R11
    .tickIn(vcoTick),
    .terminal(feedbackDivider), // R02
    .tickOut(fbTick)
  );

  pcs_lock_detect #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
    .clk_sys(clk_sys),
    .srst(srst),
    .restart(lockRestart), // R02 R04 R12 R21
    .refTick(idTick),
    .fbTick(fbTick),
    .locked(synthLocked)
  );

  // ---------------- post divider by 2^PD
  reg [15:0] postCount;
  wire [15:0] postMask = (16'h0001 << postDividerExponent) - 16'h0001;
  wire postTick = vcoTick & ((postCount & postMask) == postMask);

  always @(posedge clk_sys) begin
    if (srst || synthPowerOff) begin
      postCount <= 16'h0000; // R11
    end else if (vcoTick) begin
      postCount <= postCount + 16'h0001; // R05
    end
  end

  // ---------------- core clock selection and clock output pin
  wire synthSelected = synthOutputSelect & ~synthPowerOff; // R13
  wire sourceTick = synthSelected ? postTick : (bypassSourceSelect ? idTick : extRise); // R01 R10

  always @(posedge clk_sys) begin
    if (srst) begin
      coreClockTick <= 1'b0;
      coreMasterClock <= 1'b0;
      corePhaseZeroClock <= 1'b0;
      clockOutputPin <= 1'b0;
    end else begin
      coreClockTick <= sourceTick;
      if (sourceTick) begin
        coreMasterClock <= ~coreMasterClock;
      end
      corePhaseZeroClock <= coreMasterClock; // R09
      if (clockOutDisable) begin
        clockOutputPin <= 1'b0;
      end else if (clockOutSelect == `PCS_CS_PHASE0) begin
        clockOutputPin <= corePhaseZeroClock; // R08 R09
      end else if (clockOutSelect == `PCS_CS_EXT) begin
        clockOutputPin <= extLevel; // R08
      end else if (clockOutSelect == `PCS_CS_EXT_HALF) begin
        clockOutputPin <= extHalf; // R08
      end else begin
        clockOutputPin <= 1'b0;
      end
    end
  end
endmodule // pcs_clock_synth
`default_nettype wire

// File: test/pcs_ext_clock_model.sv
// Purpose: external clock source feeding the synthesizer
// Assumes: free-running oscillator, 80 ns period
// Notes: phase offset keeps it unrelated to clk_sys
`timescale 1ns/1ps
`default_nettype none
module pcs_ext_clock_model #(
  parameter real HALF_NS = 40.0
) (
  output var logic extClk
);
  // a crystal never stops, so the line starts low at time zero and toggles forever from 47.3 ns
  initial begin
    extClk = 1'b0;
    #7.3;
    forever #(HALF_NS) extClk = ~extClk;
  end
endmodule // pcs_ext_clock_model
`default_nettype wire

// File: test/pcs_clock_synth_asserts.sv
// Purpose: port checks for the clock synthesizer control block
// Assumes: bound to every pcs_clock_synth instance
// Notes: watches ports only
`timescale 1ns/1ps
`default_nettype none
module pcs_clock_synth_asserts #(
  parameter LOCK_CYCLES = 16,
  parameter REF_W = 20
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic clockOutDisable,
  input wire logic coreClockTick,
  input wire logic coreMasterClock,
  input wire logic corePhaseZeroClock,
  input wire logic clockOutputPin,
  input wire logic synthLocked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_fb_write;
    avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
  endsequence
  sequence s_power_off;
    avs_write && !avs_waitrequest && avs_address == 4'h4 && avs_byteenable[1] && avs_writedata[13];
  endsequence
  a_wait_one_cycle: assert property (s_req |=> !avs_waitrequest) else $error("wait too long");
  a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
  a_upper_zero: assert property (avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_fb_unlock: assert property (s_fb_write |=> !synthLocked) else $error("lock kept on divider write");
  a_off_unlock: assert property (s_power_off |=> !synthLocked [*2]) else $error("lock kept on power-off");
  a_master_tick: assert property ($changed(coreMasterClock) == coreClockTick) else $error("master off tick");
  a_phase_lag: assert property (corePhaseZeroClock == $past(coreMasterClock)) else $error("phase lag");
  a_pin_disable: assert property (clockOutDisable |=> !clockOutputPin) else $error("pin not held low");
endmodule // pcs_clock_synth_asserts
bind pcs_clock_synth pcs_clock_synth_asserts #(.LOCK_CYCLES(LOCK_CYCLES), .REF_W(REF_W)) pcs_clock_synth_asserts_inst (.*);
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for the clock synthesizer control block
// Assumes: 200 MHz clk_sys, 12.5 MHz external clock
// Notes: rates judged by counting over 640 cycles, 40 external periods
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, srst = 1'b1, avs_read, avs_write, stopMode, clockOutDisable;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata;
  logic [15:0] rd;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, externalClockInput, coreClockTick, coreMasterClock;
  wire logic corePhaseZeroClock, clockOutputPin, synthLocked;
  int fails, checks_done;
  pcs_clock_synth #(.LOCK_CYCLES(2)) pcs_clock_synth_inst (.*);
  pcs_ext_clock_model pcs_ext_clock_model_inst (.extClk(externalClockInput));
  always #2.5 clk_sys = ~clk_sys;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic lk(input logic [15:0] e);
    repeat (2) @(posedge clk_sys);
    check({15'h0000, synthLocked}, e);
  endtask
  task automatic wait_lock();
    for (int n = 0; n < 3000 && synthLocked !== 1'b1; n++) @(posedge clk_sys);
    check({15'h0000, synthLocked}, 16'h0001);
  endtask
  function automatic logic [15:0] near(int v, int e);
    return {15'h0000, v >= e - 2 && v <= e + 2};
  endfunction
  task automatic meas(output int tk, output int pr);
    logic last;
    tk = 0;
    pr = 0;
    last = clockOutputPin;
    repeat (640) begin
      @(posedge clk_sys);
      tk += coreClockTick;
      pr += (clockOutputPin && !last);
      last = clockOutputPin;
    end
  endtask
  task automatic t_regs();
    acc(0, 4'h0, 16'h0000, 4'hF); check(rd, 16'h0000);
    acc(0, 4'h4, 16'h0000, 4'hF); check(rd, 16'h0000);
    acc(1, 4'h8, 16'hFFFF, 4'hF);
    acc(0, 4'h8, 16'h0000, 4'hF); check(rd, 16'h0000);
    acc(1, 4'h0, 16'hA5C3, 4'hF);
    acc(0, 4'h0, 16'h0000, 4'hF); check(rd, 16'hA5C3);
    acc(1, 4'h4, 16'hBC00, 4'hF);
    acc(0, 4'h4, 16'h0000, 4'hF); check(rd, 16'h3C00);
    acc(1, 4'h0, 16'h0000, 4'hF);
  endtask
  task automatic t_clkout();
    logic [1:0] code[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int ep[4] = '{20, 40, 20, 0};
    int tk, pr;
    for (int i = 0; i < 4; i++) begin
      acc(1, 4'h4, {4'h0, code[i], 10'h000}, 4'hF);
      meas(tk, pr);
      check(near(tk, 40), 16'h0001);
      check(near(pr, ep[i]), 16'h0001);
    end
    clockOutDisable <= 1'b1;
    acc(1, 4'h4, 16'h0800, 4'hF);
    meas(tk, pr); check(near(pr, 0), 16'h0001);
    clockOutDisable <= 1'b0;
  endtask
  task automatic t_lock();
    int tk, pr;
    acc(1, 4'h4, 16'h0000, 4'hF);
    wait_lock();
    acc(0, 4'h4, 16'h0000, 4'hF); check(rd, 16'h8000);
    acc(1, 4'h0, 16'h1000, 4'h2); lk(16'h0001);
    acc(1, 4'h4, 16'h4000, 4'hF);
    meas(tk, pr); check(near(tk, 20), 16'h0001);
    acc(1, 4'h4, 16'h0000, 4'hF); lk(16'h0001);
    acc(1, 4'h0, 16'h0100, 4'h2); lk(16'h0000);
    wait_lock();
    acc(1, 4'h0, 16'h0003, 4'h1); lk(16'h0000);
    wait_lock();
    acc(1, 4'h4, 16'h4000, 4'hF);
    meas(tk, pr); check(near(tk, 80), 16'h0001);
    acc(1, 4'h4, 16'h0000, 4'hF);
    acc(1, 4'h4, 16'h2000, 4'hF); lk(16'h0000);
  endtask
  task automatic t_stop();
    int tk, pr;
    acc(1, 4'h4, 16'h3000, 4'hF);
    stopMode <= 1'b1;
    meas(tk, pr); check(near(tk, 0), 16'h0001);
    acc(1, 4'h4, 16'h1000, 4'hF);
    meas(tk, pr); check(near(tk, 20), 16'h0001);
    stopMode <= 1'b0;
  endtask
  initial begin
    {avs_read, avs_write, stopMode, clockOutDisable} = 4'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0000_0000;
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_clkout();
    t_lock();
    t_stop();
    tally_and_finish();
  end
  // the full sequence needs about 6500 cycles; the 80000-cycle limit allows over twelve times that
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
